//--- stack_and_interrupt_entry.sv
// Stack pointer and interrupt entry, exit and arbitration
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Byte push writes, pointer down one
// - Call or entry saves return, down two
// - Byte pop reads, pointer up one
// - Return or interrupt exit, pointer up two
// - Pointer resets to last SRAM address
// - Pointer readable/writable as two I/O bytes
// - Take source only when both enables set
// - Lowest vector wins; vectors at low memory
// - Table select moves vectors to boot start
// - Entry clears global enable
// - Entry clears the taken source's flag
// - Writing one clears a flag
// - Flag stays pending until taken or cleared
// - Level sources request only while present
// - One instruction runs after interrupt exit
// - Status flags not saved or restored
// - Global clear blocks same-cycle interrupt
// - Instruction after global set runs first
// - Entry four cycles pushing program counter
// - Multi-cycle instruction completes before entry
// - Wake from sleep adds four cycles
// - Exit four cycles, pop, pointer up two; only interrupt exit sets enable
module stack_and_interrupt_entry
  import stack_irq_pkg::*;
#(
  parameter logic [SP_WIDTH-1:0] LAST_SRAM_ADDRESS = 16'h04FF,
  parameter logic [PC_WIDTH-1:0] BOOT_START        = 14'h1C00,
  parameter int                  SP_BITS           = 11
) (
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  input  wire stack_op_type          stack_op,
  input  wire core_status_type       core_status,
  input  wire io_req_type            io_req,
  input  wire logic [PC_WIDTH-1:0]   return_pc,
  input  wire logic [NUM_SRC-1:0]    src_event,
  input  wire logic [NUM_SRC-1:0]    src_is_level,
  input  wire logic [NUM_SRC-1:0]    src_enable,
  input  wire logic                  global_enable_in,
  input  wire logic                  vector_table_select,
  input  wire logic                  boot_reset_vector_fuse,
  output logic [7:0]                 io_rdata,
  output logic                       global_enable,
  output logic [SP_WIDTH-1:0]        stack_pointer,
  output logic                       mem_wr,
  output logic                       mem_rd,
  output logic [SP_WIDTH-1:0]        mem_addr,
  output logic [7:0]                 mem_wdata,
  output logic [NUM_SRC-1:0]         irq_flags,
  output logic                       irq_busy,
  output logic                       pc_load,
  output logic [PC_WIDTH-1:0]        pc_target,
  output logic                       exit_done
);

  localparam logic [SP_WIDTH-1:0] SP_MASK =
    SP_WIDTH'((32'h1 << SP_BITS) - 32'h1);

  // Vector word address of source n, 2 words per slot, slot 0 is reset
  function automatic logic [PC_WIDTH-1:0] vector_of(input int n,
                                                    input logic sel);
    logic [PC_WIDTH-1:0] base;
    base = sel ? BOOT_START : '0;
    vector_of = base + PC_WIDTH'((n + 1) * 2);
  endfunction

  seq_state_type         state_r, state_nxt;
  logic [2:0]            cnt_r, cnt_nxt;
  logic [2:0]            last_r, last_nxt;
  logic [SP_WIDTH-1:0]   sp_r, sp_nxt;
  logic                  gie_r, gie_nxt;
  logic [NUM_SRC-1:0]    flag_r, flag_nxt;
  logic                  guard_r, guard_nxt;
  logic [PC_WIDTH-1:0]   ret_r, ret_nxt;
  logic [$clog2(NUM_SRC)-1:0] win_r, win_nxt;
  logic                  pc_load_r, pc_load_nxt;
  logic [PC_WIDTH-1:0]   pc_tgt_r, pc_tgt_nxt;
  logic                  mwr_r, mwr_nxt, mrd_r, mrd_nxt;
  logic [SP_WIDTH-1:0]   maddr_r, maddr_nxt;
  logic [7:0]            mwd_r, mwd_nxt;
  logic                  done_r, done_nxt;

  logic [NUM_SRC-1:0]    request;
  logic                  any_req;
  logic [$clog2(NUM_SRC)-1:0] winner;
  logic                  take;

  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      request[i] = (src_is_level[i] ? src_event[i] : flag_r[i])
                   & src_enable[i];
    end
    any_req = |request;
    winner  = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (request[i]) begin
        winner = ($clog2(NUM_SRC))'(i);
      end
    end
    // Global clear this cycle beats any same-cycle request
    take = any_req && gie_r && !core_status.global_clear
           && core_status.instr_boundary
           && !guard_r && state_r == ST_RUN;
  end

  always_comb begin
    state_nxt   = state_r;
    cnt_nxt     = cnt_r;
    last_nxt    = last_r;
    sp_nxt      = sp_r;
    gie_nxt     = gie_r;
    flag_nxt    = flag_r;
    guard_nxt   = guard_r;
    ret_nxt     = ret_r;
    win_nxt     = win_r;
    pc_load_nxt = 1'b0;
    pc_tgt_nxt  = pc_tgt_r;
    mwr_nxt     = 1'b0;
    mrd_nxt     = 1'b0;
    maddr_nxt   = maddr_r;
    mwd_nxt     = mwd_r;
    done_nxt    = 1'b0;
    if (guard_r && core_status.instr_boundary) begin
      guard_nxt = 1'b0;
    end
    // Status flags register is untouched here by design
    if (io_req.wr && io_req.addr == SP_LOW_ADDR) begin
      sp_nxt = {sp_r[15:8], io_req.wdata} & SP_MASK;
    end
    if (io_req.wr && io_req.addr == SP_HIGH_ADDR) begin
      sp_nxt = {io_req.wdata, sp_r[7:0]} & SP_MASK;
    end
    if (core_status.global_clear) begin
      gie_nxt = 1'b0;
    end else if (core_status.global_set) begin
      gie_nxt   = 1'b1;
      guard_nxt = 1'b1;
    end
    unique case (state_r)
      ST_RUN: begin
        if (take) begin
          state_nxt = ST_ENTRY;
          cnt_nxt   = '0;
          last_nxt  = core_status.sleeping ? WAKE_LAST : ENTRY_LAST;
          gie_nxt   = 1'b0;
          win_nxt   = winner;
          ret_nxt   = return_pc;
          flag_nxt[winner] = 1'b0;
        end else if (stack_op.push_byte) begin
          mwr_nxt   = 1'b1;
          maddr_nxt = sp_r;
          mwd_nxt   = io_req.wdata;
          sp_nxt    = (sp_r - 16'h0001) & SP_MASK;
        end else if (stack_op.pop_byte) begin
          mrd_nxt   = 1'b1;
          maddr_nxt = (sp_r + 16'h0001) & SP_MASK;
          sp_nxt    = (sp_r + 16'h0001) & SP_MASK;
        end else if (stack_op.call) begin
          state_nxt = ST_HOLD;
          cnt_nxt   = '0;
          last_nxt  = 3'h1;
          ret_nxt   = return_pc;
        end else if (stack_op.sub_exit || stack_op.irq_exit) begin
          state_nxt = ST_EXIT;
          cnt_nxt   = '0;
          last_nxt  = EXIT_LAST;
          win_nxt   = stack_op.irq_exit ? 3'h1 : 3'h0;
        end
      end
      ST_ENTRY, ST_HOLD: begin
        cnt_nxt = cnt_r + 3'h1;
        if (cnt_r == 3'h0) begin
          mwr_nxt   = 1'b1;
          maddr_nxt = sp_r;
          mwd_nxt   = ret_r[7:0];
        end else if (cnt_r == 3'h1) begin
          mwr_nxt   = 1'b1;
          maddr_nxt = (sp_r - 16'h0001) & SP_MASK;
          mwd_nxt   = 8'(ret_r >> 8);
          sp_nxt    = (sp_r - 16'h0002) & SP_MASK;
        end
        if (cnt_r == last_r) begin
          state_nxt = ST_RUN;
          if (state_r == ST_ENTRY) begin
            pc_load_nxt = 1'b1;
            pc_tgt_nxt  = vector_of(int'(win_r), vector_table_select);
          end
        end
      end
      ST_EXIT: begin
        cnt_nxt = cnt_r + 3'h1;
        if (cnt_r == 3'h0) begin
          mrd_nxt   = 1'b1;
          maddr_nxt = (sp_r + 16'h0001) & SP_MASK;
        end else if (cnt_r == 3'h1) begin
          mrd_nxt   = 1'b1;
          maddr_nxt = (sp_r + 16'h0002) & SP_MASK;
          sp_nxt    = (sp_r + 16'h0002) & SP_MASK;
        end
        if (cnt_r == last_r) begin
          state_nxt = ST_RUN;
          done_nxt  = 1'b1;
          if (win_r[0]) begin
            gie_nxt   = 1'b1;
            guard_nxt = 1'b1;
          end
        end
      end
      default: state_nxt = ST_RUN;
    endcase
    for (int i = 0; i < NUM_SRC; i++) begin
      // Hardware set beats software clear in the same cycle
      if (io_req.wr && io_req.addr == SP_HIGH_ADDR + 6'h01
          && io_req.wdata[i]) begin
        flag_nxt[i] = 1'b0;
      end
      if (src_event[i] && !src_is_level[i]) begin
        flag_nxt[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_r   <= ST_RUN;
      cnt_r     <= '0;
      last_r    <= '0;
      sp_r      <= LAST_SRAM_ADDRESS & SP_MASK;
      gie_r     <= 1'b0;
      flag_r    <= '0;
      guard_r   <= 1'b0;
      ret_r     <= '0;
      win_r     <= '0;
      pc_load_r <= 1'b0;
      pc_tgt_r  <= '0;
      mwr_r     <= 1'b0;
      mrd_r     <= 1'b0;
      maddr_r   <= '0;
      mwd_r     <= '0;
      done_r    <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      last_r    <= last_nxt;
      sp_r      <= sp_nxt;
      gie_r     <= gie_nxt;
      flag_r    <= flag_nxt;
      guard_r   <= guard_nxt;
      ret_r     <= ret_nxt;
      win_r     <= win_nxt;
      pc_load_r <= pc_load_nxt;
      pc_tgt_r  <= pc_tgt_nxt;
      mwr_r     <= mwr_nxt;
      mrd_r     <= mrd_nxt;
      maddr_r   <= maddr_nxt;
      mwd_r     <= mwd_nxt;
      done_r    <= done_nxt;
    end
  end

  always_comb begin
    unique case (io_req.addr)
      SP_LOW_ADDR:  io_rdata = sp_r[7:0];
      SP_HIGH_ADDR: io_rdata = sp_r[15:8];
      default:      io_rdata = 8'h00;
    endcase
  end

  assign global_enable = gie_r;
  assign stack_pointer = sp_r;
  assign mem_wr        = mwr_r;
  assign mem_rd        = mrd_r;
  assign mem_addr      = maddr_r;
  assign mem_wdata     = mwd_r;
  assign irq_flags     = flag_r;
  assign irq_busy      = state_r != ST_RUN;
  assign pc_load       = pc_load_r;
  assign pc_target     = pc_tgt_r;
  assign exit_done     = done_r;

  push_down_a: assert property (@(posedge sys_clk) disable iff (reset)
    state_r == ST_RUN && !take && stack_op.push_byte && !io_req.wr
    |=> sp_r == (($past(sp_r) - 16'h0001) & SP_MASK))
    else $error("push did not lower pointer by one");
  pop_up_a: assert property (@(posedge sys_clk) disable iff (reset)
    state_r == ST_RUN && !take && !stack_op.push_byte
    && stack_op.pop_byte && !io_req.wr
    |=> sp_r == (($past(sp_r) + 16'h0001) & SP_MASK))
    else $error("pop did not raise pointer by one");
  entry_len_a: assert property (@(posedge sys_clk) disable iff (reset)
    take && !core_status.sleeping |=> ##4 pc_load)
    else $error("entry did not vector after four cycles");
  wake_len_a: assert property (@(posedge sys_clk) disable iff (reset)
    take && core_status.sleeping |=> !pc_load [*8] ##1 pc_load)
    else $error("wake entry not eight cycles");
  entry_gie_a: assert property (@(posedge sys_clk) disable iff (reset)
    take |=> !gie_r)
    else $error("entry left global enable set");
  clear_block_a: assert property (@(posedge sys_clk) disable iff (reset)
    core_status.global_clear |-> !take)
    else $error("interrupt taken with global clear");
  need_enable_a: assert property (@(posedge sys_clk) disable iff (reset)
    take |-> gie_r && src_enable[winner])
    else $error("interrupt taken while disabled");
  exit_gie_a: assert property (@(posedge sys_clk) disable iff (reset)
    state_r == ST_RUN && !take && stack_op.irq_exit && !stack_op.push_byte
    && !stack_op.pop_byte && !stack_op.call
    |=> ##4 gie_r && guard_r && exit_done)
    else $error("interrupt exit not four cycles");
  flag_clr_a: assert property (@(posedge sys_clk) disable iff (reset)
    take && !src_event[winner] |=> !flag_r[$past(winner)])
    else $error("taken flag not cleared");

endmodule // stack_and_interrupt_entry

`default_nettype wire

//--- stack_irq_pkg.sv
// Constants and types for the stack and interrupt entry unit
package stack_irq_pkg;
  localparam logic [5:0] SP_HIGH_ADDR = 6'h3E;   // I/O address of high half
  localparam logic [5:0] SP_LOW_ADDR  = 6'h3D;   // I/O address of low half
  localparam int         SP_WIDTH     = 16;
  localparam int         PC_WIDTH     = 14;
  localparam int         NUM_SRC      = 8;
  localparam int         ENTRY_CYCLES = 4;
  localparam int         WAKE_CYCLES  = 4;
  localparam int         EXIT_CYCLES  = 4;
  localparam logic [2:0] ENTRY_LAST   = 3'(ENTRY_CYCLES - 1);
  localparam logic [2:0] WAKE_LAST    = 3'(ENTRY_CYCLES + WAKE_CYCLES - 1);
  localparam logic [2:0] EXIT_LAST    = 3'(EXIT_CYCLES - 1);

  typedef enum logic [3:0] {
    ST_RUN   = 4'h1,
    ST_ENTRY = 4'h2,
    ST_EXIT  = 4'h4,
    ST_HOLD  = 4'h8
  } seq_state_type;

  // Stack operations offered by the instruction sequencer
  typedef struct packed {
    logic push_byte;
    logic pop_byte;
    logic call;
    logic sub_exit;
    logic irq_exit;
  } stack_op_type;

  // Per-cycle status from the sequencer
  typedef struct packed {
    logic instr_boundary;
    logic sleeping;
    logic global_clear;
    logic global_set;
  } core_status_type;

  // I/O register access port
  typedef struct packed {
    logic       wr;
    logic [5:0] addr;
    logic [7:0] wdata;
  } io_req_type;
endpackage

//--- irq_source_model.sv
// Peripheral interrupt source model for the stack and interrupt unit
`timescale 1ns/1ps
`default_nettype none
module irq_source_model
  import stack_irq_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               reset,
  input  wire logic [NUM_SRC-1:0] fire,
  input  wire logic [NUM_SRC-1:0] hold,
  output logic      [NUM_SRC-1:0] src_event,
  output logic      [NUM_SRC-1:0] src_is_level
);
  // Upper four sources are level type, with no flag behind them
  assign src_is_level = 8'hF0;
  // Edge sources give one-cycle events; level ones last only while held
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      src_event <= '0;
    end else begin
      src_event <= (fire & ~src_is_level) | (hold & src_is_level);
    end
  end
endmodule // irq_source_model
`default_nettype wire

//--- test_stack_and_interrupt_entry.sv
// Self-checking bench for the stack and interrupt entry unit
`timescale 1ns/1ps
`default_nettype none
module test_stack_and_interrupt_entry
  import stack_irq_pkg::*;
;
  localparam logic [15:0] SP_RESET = 16'h04FF;
  localparam logic [13:0] BOOT     = 14'h1C00;
  logic                sys_clk;
  logic                reset;
  stack_op_type        stack_op;
  core_status_type     core_status;
  io_req_type          io_req;
  logic [NUM_SRC-1:0]  fire;
  logic [NUM_SRC-1:0]  hold;
  logic [NUM_SRC-1:0]  src_event;
  logic [NUM_SRC-1:0]  src_is_level;
  logic [NUM_SRC-1:0]  src_enable;
  logic                vts;
  logic [7:0]          io_rdata;
  logic                global_enable;
  logic [SP_WIDTH-1:0] stack_pointer;
  logic                mem_wr;
  logic                mem_rd;
  logic [SP_WIDTH-1:0] mem_addr;
  logic [7:0]          mem_wdata;
  logic [NUM_SRC-1:0]  irq_flags;
  logic                irq_busy;
  logic                pc_load;
  logic [PC_WIDTH-1:0] pc_target;
  logic                exit_done;
  int                  error_cnt;
  int                  checks;
  int                  n;

  irq_source_model u_irq_source_model (.sys_clk(sys_clk), .reset(reset),
    .fire(fire), .hold(hold), .src_event(src_event),
    .src_is_level(src_is_level));

  stack_and_interrupt_entry #(.LAST_SRAM_ADDRESS(SP_RESET),
    .BOOT_START(BOOT), .SP_BITS(11)) u_stack_and_interrupt_entry (
    .sys_clk(sys_clk), .reset(reset), .stack_op(stack_op),
    .core_status(core_status), .io_req(io_req), .return_pc(14'h0123),
    .src_event(src_event), .src_is_level(src_is_level),
    .src_enable(src_enable), .global_enable_in(1'b0),
    .vector_table_select(vts), .boot_reset_vector_fuse(1'b0),
    .io_rdata(io_rdata), .global_enable(global_enable),
    .stack_pointer(stack_pointer), .mem_wr(mem_wr), .mem_rd(mem_rd),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .irq_flags(irq_flags),
    .irq_busy(irq_busy), .pc_load(pc_load), .pc_target(pc_target),
    .exit_done(exit_done));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic print_verdict();
    $display("Checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] e,
                     input logic [15:0] got);
    checks++;
    if (got !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, e, got);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  // Sel: 0 busy, 1 pc_load, 2 exit_done, 3 idle; counts edges waited
  task automatic wait_sig(input int sel, output int cnt);
    cnt = 0;
    do begin
      tick(1);
      cnt++;
      if (cnt > 40) begin
        error_cnt++;
        $display("Error wait %0d expected event seen none", sel);
        print_verdict();
      end
    end while (!(sel == 0 ? irq_busy === 1'b1 : sel == 1 ? pc_load === 1'b1
               : sel == 2 ? exit_done === 1'b1 : irq_busy === 1'b0));
  endtask

  task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    io_req <= '{1'b1, a, d};
    @(posedge sys_clk);
    io_req.wr <= 1'b0;
    #1;
  endtask

  task automatic io_rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    io_req <= '{1'b0, a, 8'h00};
    #1;
    chk("io_rdata", {8'h00, e}, {8'h00, io_rdata});
  endtask

  task automatic do_op(input logic [4:0] op, input logic [7:0] d);
    @(posedge sys_clk);
    stack_op <= stack_op_type'(op);
    io_req.wdata <= d;
    @(posedge sys_clk);
    stack_op <= '0;
    #1;
  endtask

  task automatic set_gie();
    @(posedge sys_clk);
    core_status.global_set <= 1'b1;
    @(posedge sys_clk);
    core_status.global_set <= 1'b0;
  endtask

  task automatic fire_src(input int k);
    @(posedge sys_clk);
    fire <= NUM_SRC'(1) << k;
    @(posedge sys_clk);
    fire <= '0;
    tick(3);
  endtask

  // Caller leaves the unit idle and the request already on its way
  task automatic t_entry(input logic [13:0] vec, input int cyc,
                         input logic [15:0] sp);
    wait_sig(0, n);
    wait_sig(1, n);
    chk("entry cycles", 16'(cyc), 16'(n));
    chk("pc_target", 16'(vec), 16'(pc_target));
    chk("gie entry", 16'h0000, 16'(global_enable));
    chk("sp entry", sp, stack_pointer);
  endtask

  task automatic t_exit(input logic [15:0] sp);
    wait_sig(3, n);
    do_op(5'h01, 8'h00);
    wait_sig(2, n);
    chk("exit cycles", 16'(EXIT_CYCLES), 16'(n));
    chk("gie exit", 16'h0001, 16'(global_enable));
    chk("sp exit", sp, stack_pointer);
  endtask

  task automatic t_registers();
    chk("sp reset", SP_RESET, stack_pointer);
    io_rd(SP_LOW_ADDR, SP_RESET[7:0]);
    io_rd(SP_HIGH_ADDR, SP_RESET[15:8]);
    io_wr(SP_HIGH_ADDR, 8'h03);
    io_wr(SP_LOW_ADDR, 8'h80);
    chk("sp written", 16'h0380, stack_pointer);
    io_rd(SP_LOW_ADDR, 8'h80);
    io_rd(6'h10, 8'h00);
  endtask

  task automatic t_stack_ops();
    do_op(5'h10, 8'hA5);
    chk("push wr", 16'h0001, 16'(mem_wr));
    chk("push addr", 16'h0380, mem_addr);
    chk("push data", 16'h00A5, 16'(mem_wdata));
    chk("sp push", 16'h037F, stack_pointer);
    do_op(5'h08, 8'h00);
    chk("pop rd", 16'h0001, 16'(mem_rd));
    chk("pop addr", 16'h0380, mem_addr);
    chk("sp pop", 16'h0380, stack_pointer);
    do_op(5'h04, 8'h00);
    tick(1);
    chk("call lo addr", 16'h0380, mem_addr);
    chk("call lo data", 16'h0023, 16'(mem_wdata));
    tick(1);
    chk("call hi wr", 16'h0001, 16'(mem_wr));
    chk("call hi addr", 16'h037F, mem_addr);
    chk("call hi data", 16'h0001, 16'(mem_wdata));
    wait_sig(3, n);
    chk("sp call", 16'h037E, stack_pointer);
    do_op(5'h02, 8'h00);
    wait_sig(3, n);
    chk("sp return", 16'h0380, stack_pointer);
  endtask

  task automatic t_irq_take();
    fire_src(3);
    fire_src(1);
    chk("flags held", 16'h000A, 16'(irq_flags));
    set_gie();
    tick(4);
    chk("busy masked", 16'h0000, 16'(irq_busy));
    @(posedge sys_clk);
    src_enable <= 8'h08;
    core_status.global_clear <= 1'b1;
    @(posedge sys_clk);
    core_status.global_clear <= 1'b0;
    tick(5);
    chk("busy cleared", 16'h0000, 16'(irq_busy));
    @(posedge sys_clk);
    src_enable <= 8'h0A;
    set_gie();
    t_entry(14'h0004, ENTRY_CYCLES, 16'h037E);
    chk("flag cleared", 16'h0008, 16'(irq_flags));
  endtask

  task automatic t_irq_return();
    @(posedge sys_clk);
    core_status.sleeping <= 1'b1;
    vts <= 1'b1;
    t_exit(16'h0380);
    wait_sig(3, n);
    t_entry(BOOT + 14'h0008, ENTRY_CYCLES + WAKE_CYCLES, 16'h037E);
    @(posedge sys_clk);
    core_status.sleeping <= 1'b0;
    vts <= 1'b0;
    t_exit(16'h0380);
  endtask

  task automatic t_flags_and_level();
    fire_src(2);
    io_wr(6'h3F, 8'h00);
    chk("flag kept", 16'h0004, 16'(irq_flags));
    io_wr(6'h3F, 8'h04);
    chk("flag wiped", 16'h0000, 16'(irq_flags));
    @(posedge sys_clk);
    hold <= 8'h40;
    tick(4);
    hold <= '0;
    tick(2);
    src_enable <= 8'h4A;
    tick(6);
    chk("level gone", 16'h0000, 16'(irq_busy));
    hold <= 8'h40;
    t_entry(14'h000E, ENTRY_CYCLES, 16'h037E);
    hold <= '0;
    t_exit(16'h0380);
  endtask

  // Pending request must wait for the instruction boundary
  task automatic t_boundary();
    @(posedge sys_clk);
    core_status.instr_boundary <= 1'b0;
    fire_src(1);
    tick(4);
    chk("busy mid instr", 16'h0000, 16'(irq_busy));
    @(posedge sys_clk);
    core_status.instr_boundary <= 1'b1;
    t_entry(14'h0004, ENTRY_CYCLES, 16'h037E);
    t_exit(16'h0380);
  endtask

  initial begin
    reset = 1'b1;
    stack_op = '0;
    core_status = '0;
    core_status.instr_boundary = 1'b1;
    io_req = '0;
    fire = '0;
    hold = '0;
    src_enable = '0;
    vts = 1'b0;
    error_cnt = 0;
    checks = 0;
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    tick(1);
    t_registers();
    t_stack_ops();
    t_irq_take();
    t_irq_return();
    t_flags_and_level();
    t_boundary();
    print_verdict();
  end
endmodule // test_stack_and_interrupt_entry
`default_nettype wire
